//--- src/lcc_top.sv
// Lead-on detector filtering, calibration control registers and interrupt
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module lcc_top
   import lcc_pkg::*;
#(
   parameter int unsigned PERSIST_CYC = lcc_pkg::LON_PERSIST_CYC
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // Register port
   input wire logic [lcc_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [lcc_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [lcc_pkg::DATA_W-1:0] reg_rdata_out,
   // Analog comparator, high while the positive input is below threshold
   input wire logic lead_on_cmp_in,
   // Analog controls
   output logic lon_detect_en_out,
   output logic inphase_channel_enable_out,
   output logic quadrature_channel_enable_out,
   output logic [1:0] voltage_drive_magnitude_out,
   output logic [1:0] current_drive_range_out,
   output logic load_short_enable_out,
   output logic quad_demod_phase_select_out,
   output logic inphase_demod_phase_select_out,
   output logic input_mux_enable_out,
   output logic cal_enable_out,
   // Interrupt
   output logic irq_out
);
   import lcc_pkg::*;

   logic [7:0] chan_en_ff;
   logic [7:0] drive_mag_ff;
   logic [7:0] drive_ctrl_ff;
   logic [7:0] phase_ff;
   logic [7:0] cal_mux_ff;
   logic [7:0] irq_mask_ff;
   logic [7:0] lon_ctrl_ff;
   logic lead_on_status_ff;
   logic [7:0] rdata_ff;
   logic irq_ff;
   logic cmp_meta_ff;
   logic cmp_sync_ff;
   logic lon_held;
   logic lon_held_d_ff;

   // Comparator crosses in from the analog domain
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         cmp_meta_ff <= 1'b0;
         cmp_sync_ff <= 1'b0;
      end else begin
         cmp_meta_ff <= lead_on_cmp_in;
         cmp_sync_ff <= cmp_meta_ff;
      end
   end

   wire lon_enabled = lon_ctrl_ff[BIT_LON_DET_EN];
   wire cmp_level = cmp_sync_ff && lon_enabled;

   lcc_persist_timer #(
      .COUNT(PERSIST_CYC),
      .CNT_W(32)
   ) u_persist (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .level_in(cmp_level),
      .held_out(lon_held)
   );

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         lon_held_d_ff <= 1'b0;
      end else begin
         lon_held_d_ff <= lon_held;
      end
   end
   wire lon_event = lon_held && !lon_held_d_ff;

   // Address decode
   wire sel_status = (reg_addr_in == ADDR_STATUS);
   wire sel_chan = (reg_addr_in == ADDR_CHAN_EN);
   wire sel_mag = (reg_addr_in == ADDR_DRIVE_MAG);
   wire sel_ctrl = (reg_addr_in == ADDR_DRIVE_CTRL);
   wire sel_phase = (reg_addr_in == ADDR_DEMOD_PHASE);
   wire sel_cal = (reg_addr_in == ADDR_CAL_MUX);
   wire sel_mask = (reg_addr_in == ADDR_IRQ_MASK);
   wire sel_lon = (reg_addr_in == ADDR_LON_CTRL);
   wire status_rd = reg_rd_in && sel_status;

   // Writable fields only; others read zero
   wire [7:0] chan_wmask = 8'h03;
   wire [7:0] mag_wmask = 8'h3C;
   wire [7:0] ctrl_wmask = 8'h20;
   wire [7:0] phase_wmask = 8'h0C;
   wire [7:0] cal_wmask = 8'h03;
   wire [7:0] mask_wmask = 8'h80;
   wire [7:0] lon_wmask = 8'h01;

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         chan_en_ff <= RST_REG;
         drive_mag_ff <= RST_REG;
         drive_ctrl_ff <= RST_REG;
         phase_ff <= RST_REG;
         cal_mux_ff <= RST_REG;
         irq_mask_ff <= RST_REG;
         lon_ctrl_ff <= RST_REG;
      end else if (reg_wr_in) begin
         if (sel_chan) chan_en_ff <= reg_wdata_in & chan_wmask;
         if (sel_mag) drive_mag_ff <= reg_wdata_in & mag_wmask;
         if (sel_ctrl) drive_ctrl_ff <= reg_wdata_in & ctrl_wmask;
         if (sel_phase) phase_ff <= reg_wdata_in & phase_wmask;
         if (sel_cal) cal_mux_ff <= reg_wdata_in & cal_wmask;
         if (sel_mask) irq_mask_ff <= reg_wdata_in & mask_wmask;
         if (sel_lon) lon_ctrl_ff <= reg_wdata_in & lon_wmask;
      end
   end

   // clear on read, a new event wins
   wire nxt_status = lon_event | (lead_on_status_ff & !status_rd);
   wire [7:0] status_word = {lead_on_status_ff, 7'b000_0000};

   assign reg_rdata_out = rdata_ff;
   wire [7:0] nxt_rdata =
      sel_status ? status_word :
      sel_chan ? chan_en_ff :
      sel_mag ? drive_mag_ff :
      sel_ctrl ? drive_ctrl_ff :
      sel_phase ? phase_ff :
      sel_cal ? cal_mux_ff :
      sel_mask ? irq_mask_ff :
      sel_lon ? lon_ctrl_ff : 8'h00;

   wire nxt_irq = nxt_status && irq_mask_ff[BIT_LEAD_ON];

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         lead_on_status_ff <= 1'b0;
         rdata_ff <= 8'h00;
         irq_ff <= 1'b0;
      end else begin
         lead_on_status_ff <= nxt_status;
         rdata_ff <= reg_rd_in ? nxt_rdata : 8'h00;
         irq_ff <= nxt_irq;
      end
   end
   assign irq_out = irq_ff;

   // Analog controls come straight from registers
   assign lon_detect_en_out = lon_ctrl_ff[BIT_LON_DET_EN];
   assign inphase_channel_enable_out = chan_en_ff[BIT_INPHASE_EN];
   assign quadrature_channel_enable_out = chan_en_ff[BIT_QUAD_EN];
   assign voltage_drive_magnitude_out = drive_mag_ff[BIT_VDRV_LO +: 2];
   assign current_drive_range_out = drive_mag_ff[BIT_IDRV_LO +: 2];
   assign load_short_enable_out = drive_ctrl_ff[BIT_LOAD_SHORT];
   assign quad_demod_phase_select_out = phase_ff[BIT_QUAD_PHASE];
   assign inphase_demod_phase_select_out = phase_ff[BIT_INPHASE_PHASE];
   assign input_mux_enable_out = cal_mux_ff[BIT_INPUT_MUX_ENABLE];
   assign cal_enable_out = cal_mux_ff[BIT_CAL_EN];

   // Helper: cycles the comparator has held
   logic [31:0] hold_cnt_ff;
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in || !cmp_level) begin
         hold_cnt_ff <= '0;
      end else if (hold_cnt_ff != 32'hFFFF_FFFF) begin
         hold_cnt_ff <= hold_cnt_ff + 1'b1;
      end
   end

   a_status_after_hold: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      $rose(lead_on_status_ff) |-> hold_cnt_ff >= 32'(PERSIST_CYC))
      else $error("lead-on set before persistence time");
   a_timer_restart: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      !cmp_level |=> !lon_held) else $error("timer not restarted");
   a_irq_masked: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      irq_out |-> $past(irq_mask_ff[BIT_LEAD_ON])) else $error("irq while masked");
   a_irq_follows: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      irq_out == (lead_on_status_ff && $past(irq_mask_ff[BIT_LEAD_ON])))
      else $error("irq mismatch");
   a_read_clears: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      status_rd && !lon_event |=> !lead_on_status_ff) else $error("status not cleared");
   a_event_sets: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      lon_event |=> lead_on_status_ff
      && (!$past(status_rd) || reg_rdata_out[7] == $past(lead_on_status_ff)))
      else $error("event lost");
   a_short_write: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      reg_wr_in && sel_ctrl |=> load_short_enable_out == $past(reg_wdata_in[BIT_LOAD_SHORT]))
      else $error("load short not written");
   a_chan_write: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      reg_wr_in && sel_chan |=> inphase_channel_enable_out == $past(reg_wdata_in[0])
      && quadrature_channel_enable_out == $past(reg_wdata_in[1]))
      else $error("channel enables not written");
   a_phase_write: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      reg_wr_in && sel_phase |=> quad_demod_phase_select_out == $past(reg_wdata_in[3])
      && inphase_demod_phase_select_out == $past(reg_wdata_in[2]))
      else $error("phase selects not written");

   c_lead_on: cover property (@(posedge mclk_in) $rose(lead_on_status_ff));
   c_irq: cover property (@(posedge mclk_in) $rose(irq_out));
   c_clear: cover property (@(posedge mclk_in) status_rd && lead_on_status_ff);
   c_cal_phase: cover property (@(posedge mclk_in)
      quad_demod_phase_select_out && load_short_enable_out == 1'b0);
endmodule
`default_nettype wire

//--- src/lcc_pkg.sv
// Package: register map, field positions, reset values and timing for the lead-on/calibration block
package lcc_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // Register addresses
   localparam logic [7:0] ADDR_STATUS = 8'h01;
   localparam logic [7:0] ADDR_CHAN_EN = 8'h20;
   localparam logic [7:0] ADDR_DRIVE_MAG = 8'h22;
   localparam logic [7:0] ADDR_DRIVE_CTRL = 8'h25;
   localparam logic [7:0] ADDR_DEMOD_PHASE = 8'h28;
   localparam logic [7:0] ADDR_CAL_MUX = 8'h41;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h81;
   localparam logic [7:0] ADDR_LON_CTRL = 8'h90;

   // Field positions
   localparam int unsigned BIT_LEAD_ON = 7;
   localparam int unsigned BIT_INPHASE_EN = 0;
   localparam int unsigned BIT_QUAD_EN = 1;
   localparam int unsigned BIT_VDRV_LO = 4;
   localparam int unsigned BIT_IDRV_LO = 2;
   localparam int unsigned BIT_LOAD_SHORT = 5;
   localparam int unsigned BIT_QUAD_PHASE = 3;
   localparam int unsigned BIT_INPHASE_PHASE = 2;
   localparam int unsigned BIT_CAL_EN = 0;
   localparam int unsigned BIT_INPUT_MUX_ENABLE = 1;
   localparam int unsigned BIT_LON_DET_EN = 0;

   // Reset values
   localparam logic [7:0] RST_REG = 8'h00;

   // Lead-on persistence time
   localparam int unsigned CLK_FREQ_HZ = 125_000_000;
   localparam int unsigned LON_PERSIST_MS = 128;
   localparam int unsigned LON_PERSIST_CYC = CLK_FREQ_HZ / 1000 * LON_PERSIST_MS;
endpackage

//--- src/lcc_persist_timer.sv
// Persistence timer: flags a level that has held for a given number of clock cycles
`timescale 1ns/100ps
`default_nettype none
module lcc_persist_timer #(
   parameter int unsigned COUNT = 16,
   parameter int unsigned CNT_W = 32
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // Level in, qualified level out
   input wire logic level_in,
   output logic held_out
);
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic held_ff;
   wire at_end = (cnt_ff >= CNT_W'(COUNT - 1));

   assign nxt_cnt = !level_in ? '0 : (at_end ? cnt_ff : cnt_ff + 1'b1);

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         cnt_ff <= '0;
         held_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         held_ff <= level_in && at_end;
      end
   end
   assign held_out = held_ff;

   a_held_needs_level: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      held_out |-> $past(level_in)) else $error("held without level");
endmodule
`default_nettype wire

//--- bench/lcc_host_model.sv
// Host microcontroller model: register port master and interrupt service
`timescale 1ns/100ps
`default_nettype none
module lcc_host_model
   import lcc_pkg::*;
(
   // Clock
   input wire logic mclk_in,
   // Register port
   output logic [lcc_pkg::ADDR_W-1:0] reg_addr_out,
   output logic [lcc_pkg::DATA_W-1:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   input wire logic [lcc_pkg::DATA_W-1:0] reg_rdata_in
);
   initial begin
      reg_addr_out = 8'h00;
      reg_wdata_out = 8'h00;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      reg_addr_out <= a;
      reg_wdata_out <= d;
      reg_wr_out <= 1'b1;
      @(posedge mclk_in);
      reg_wr_out <= 1'b0;
      // Idle data is scrambled so stale values cannot pass
      reg_wdata_out <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_in);
      reg_addr_out <= a;
      reg_rd_out <= 1'b1;
      @(posedge mclk_in);
      reg_rd_out <= 1'b0;
      #1 d = reg_rdata_in;
   endtask
   task automatic service_irq(output logic [7:0] first, output logic [7:0] second);
      rd(ADDR_STATUS, first);
      rd(ADDR_STATUS, second);
   endtask
   // synthesis frequency and offset scaling stay with the host
   task automatic cal_offset();
      wr(ADDR_CAL_MUX, 8'h03);
      wr(ADDR_DRIVE_MAG, 8'h00);
      wr(ADDR_DRIVE_CTRL, 8'h20);
      wr(ADDR_CHAN_EN, 8'h03);
   endtask
   task automatic arm_lead_on(input logic [7:0] mask);
      wr(ADDR_CHAN_EN, 8'h00);
      wr(ADDR_IRQ_MASK, mask);
      wr(ADDR_LON_CTRL, 8'h01);
   endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the lead-on and calibration control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import lcc_pkg::*;
   localparam int unsigned PERSIST = 20;
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic cmp = 1'b0;
   logic [7:0] addr, wdata, rdata;
   logic wr, rd, lon_en, i_en, q_en, short, qph, iph, mux, cal, irq_out;
   logic [1:0] vdrv, idrv;
   wire [11:0] ctl = {lon_en, i_en, q_en, vdrv, idrv, short, qph, iph, mux, cal};
   int fails = 0;
   int n_checks = 0;
   logic [7:0] ra [9] = '{8'h20, 8'h22, 8'h25, 8'h28, 8'h41, 8'h90, 8'h81, 8'h55, 8'h01};
   logic [7:0] rm [9] = '{8'h03, 8'h3C, 8'h20, 8'h0C, 8'h03, 8'h01, 8'h80, 8'h00, 8'h00};
   logic [11:0] rc [9] = '{12'h600, 12'h1E0, 12'h010, 12'h00C, 12'h003, 12'h800, 0, 0, 0};
   always #4 mclk_in = ~mclk_in;
   lcc_host_model u_lcc_host_model (.mclk_in(mclk_in), .reg_addr_out(addr),
      .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata));
   lcc_top #(.PERSIST_CYC(PERSIST)) u_lcc_top (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .lead_on_cmp_in(cmp), .lon_detect_en_out(lon_en),
      .inphase_channel_enable_out(i_en), .quadrature_channel_enable_out(q_en),
      .voltage_drive_magnitude_out(vdrv), .current_drive_range_out(idrv),
      .load_short_enable_out(short), .quad_demod_phase_select_out(qph),
      .inphase_demod_phase_select_out(iph), .input_mux_enable_out(mux),
      .cal_enable_out(cal), .irq_out(irq_out));
   task automatic complete_run();
      if (fails == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask
   task automatic wait_irq(output int n);
      n = 0;
      while (irq_out !== 1'b1) begin
         @(posedge mclk_in);
         #1 n++;
         if (n > 100) begin
            fails++;
            complete_run();
         end
      end
   endtask
   initial begin
      logic [7:0] d, d2;
      int n;
      repeat (6) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      #1 chk(ctl, 12'h000, "outputs after reset");
      for (int i = 0; i < 9; i++) begin
         u_lcc_host_model.rd(ra[i], d);
         chk(d, 8'h00, "reset value");
         u_lcc_host_model.wr(ra[i], 8'hFF);
         u_lcc_host_model.rd(ra[i], d);
         chk(d, rm[i], "readback");
         chk(ctl, rc[i], "control outputs");
         u_lcc_host_model.wr(ra[i], 8'h00);
      end
      u_lcc_host_model.wr(ADDR_DRIVE_MAG, 8'h24);
      #1 chk(ctl, 12'h120, "drive fields");
      u_lcc_host_model.wr(ADDR_DRIVE_MAG, 8'h00);
      #1 chk(ctl, 12'h000, "drive fields zero");
      u_lcc_host_model.cal_offset();
      #1 chk(ctl, 12'h613, "offset step controls");
      u_lcc_host_model.arm_lead_on(8'h80);
      cmp <= 1'b1;
      repeat (PERSIST - 4) @(posedge mclk_in);
      cmp <= 1'b0;
      repeat (3) @(posedge mclk_in);
      cmp <= 1'b1;
      repeat (PERSIST - 4) @(posedge mclk_in);
      #1 chk(irq_out, 1'b0, "early lead-on");
      wait_irq(n);
      n = n + PERSIST - 4;
      chk(n >= PERSIST && n <= PERSIST + 4, 1'b1, "persistence time");
      u_lcc_host_model.service_irq(d, d2);
      chk(d, 8'h80, "first status read");
      chk(d2, 8'h00, "second status read");
      chk(irq_out, 1'b0, "irq after read");
      cmp <= 1'b0;
      u_lcc_host_model.wr(ADDR_IRQ_MASK, 8'h00);
      repeat (2) @(posedge mclk_in);
      cmp <= 1'b1;
      repeat (PERSIST + 10) @(posedge mclk_in);
      #1 chk(irq_out, 1'b0, "masked lead-on");
      u_lcc_host_model.wr(ADDR_IRQ_MASK, 8'h80);
      @(posedge mclk_in);
      #1 chk(irq_out, 1'b1, "unmasked pending");
      u_lcc_host_model.rd(ADDR_STATUS, d);
      chk(d, 8'h80, "masked event status");
      chk(irq_out, 1'b0, "irq cleared");
      complete_run();
   end
endmodule
`default_nettype wire
